/* File: cfg_pin_pkg.sv */
// shared constants and types for the configuration pin control block
// assumes one clock domain; all pin levels arrive already synchronous

package cfg_pin_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int MODE_W = 4;
    localparam int NUM_PLL_PINS = 8;
    localparam int NUM_PCLK_PINS = 8;
    localparam int FRAME_W = 16;
    localparam int FADDR_W = 8;
    localparam int BITCNT_W = 4;

    // ----------------------------------------------------------------
    // readback frame range
    // ----------------------------------------------------------------
    localparam logic [FADDR_W-1:0] RB_FIRST_FRAME = 8'h00;
    localparam logic [FADDR_W-1:0] RB_LAST_FRAME = 8'h3F;
    localparam logic [BITCNT_W-1:0] RB_LAST_BIT = 4'hF;

    // ----------------------------------------------------------------
    // mode select codes and reset value
    // ----------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_MASTER = 4'h0;
    localparam logic [MODE_W-1:0] MODE_ASYNC_PERIPH = 4'h1;
    localparam logic [MODE_W-1:0] MODE_SLAVE = 4'h2;
    localparam logic [MODE_W-1:0] MODE_JTAG = 4'h3;
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;

    // ----------------------------------------------------------------
    // edge detector lanes
    // ----------------------------------------------------------------
    localparam int EDGE_N = 3;
    localparam int EDGE_INIT = 0;
    localparam int EDGE_TRIG = 1;
    localparam int EDGE_CFG_CLOCK = 2;
    localparam logic [EDGE_N-1:0] EDGE_RST = 3'h3;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_CFG = 3'b010,
        ST_USER = 3'b100
    } cfg_state_t;

    typedef struct packed {
        logic ts_after_cfg;
        logic readback_en;
    } cfg_opt_t;

    typedef struct packed {
        logic used;
        logic irq;
    } host_port_t;

endpackage : cfg_pin_pkg

/* File: pin_edge_detect.sv */
// rising and falling edge detection on already synchronous pin levels
// assumes inputs are synchronous to i_mclk, so no synchroniser stage

`timescale 1ns/1ps

module pin_edge_detect (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [cfg_pin_pkg::EDGE_N-1:0] i_level,
    output logic [cfg_pin_pkg::EDGE_N-1:0] o_rise,
    output logic [cfg_pin_pkg::EDGE_N-1:0] o_fall
);
    logic [cfg_pin_pkg::EDGE_N-1:0] prev_q;
    logic [cfg_pin_pkg::EDGE_N-1:0] prev_d;

    always_comb begin
        prev_d = i_level;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            // init and trigger idle high, so no false edge after reset
            prev_q <= cfg_pin_pkg::EDGE_RST;
        end else begin
            prev_q <= prev_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < cfg_pin_pkg::EDGE_N; g++) begin : g_edge
            assign o_rise[g] = i_level[g] & ~prev_q[g];
            assign o_fall[g] = ~i_level[g] & prev_q[g];
        end
    endgenerate

endmodule : pin_edge_detect

/* File: readback_shifter.sv */
// serialises configuration frames, msb first, one bit per cfg clock rising edge
// assumes i_word holds the frame at o_addr; it is read in the same cycle

`timescale 1ns/1ps

module readback_shifter (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic i_shift,
    input wire logic [cfg_pin_pkg::FRAME_W-1:0] i_word,
    output logic [cfg_pin_pkg::FADDR_W-1:0] o_addr,
    output logic o_bit,
    output logic o_busy
);
    logic busy_q, busy_d;
    logic bit_q, bit_d;
    logic [cfg_pin_pkg::FADDR_W-1:0] addr_q, addr_d;
    logic [cfg_pin_pkg::BITCNT_W-1:0] cnt_q, cnt_d;
    logic last;

    assign last = (addr_q == cfg_pin_pkg::RB_LAST_FRAME) && (cnt_q == cfg_pin_pkg::RB_LAST_BIT);

    always_comb begin
        busy_d = busy_q;
        bit_d = bit_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        if (i_start) begin
            // a new trigger restarts from the first frame
            busy_d = 1'b1;
            addr_d = cfg_pin_pkg::RB_FIRST_FRAME;
            cnt_d = '0;
        end else if (busy_q && i_shift) begin
            bit_d = i_word[cfg_pin_pkg::RB_LAST_BIT - cnt_q];
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == cfg_pin_pkg::RB_LAST_BIT) begin
                addr_d = addr_q + 8'h01;
            end
            if (last) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            busy_q <= 1'b0;
            bit_q <= 1'b0;
            addr_q <= cfg_pin_pkg::RB_FIRST_FRAME;
            cnt_q <= '0;
        end else begin
            busy_q <= busy_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_addr = addr_q;
    assign o_bit = bit_q;
    assign o_busy = busy_q;

    property p_rb_stop;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (busy_q && i_shift && !i_start && last) |=> !busy_q;
    endproperty
    a_rb_stop: assert property (p_rb_stop) else $error("readback did not stop after last frame");

    property p_rb_shift;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (busy_q && i_shift && !i_start) |=> (cnt_q == $past(cnt_q) + 4'h1);
    endproperty
    a_rb_shift: assert property (p_rb_shift) else $error("readback bit count did not advance");

endmodule : readback_shifter

/* File: config_pin_control.sv */
// configuration pin control: mode latch, tristate-all, readback, error/irq pin
// assumes all pin levels are synchronous to i_mclk; no register bus

`timescale 1ns/1ps

module config_pin_control (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_init_pin,
    input wire logic [cfg_pin_pkg::MODE_W-1:0] i_mode_sel,
    input wire logic i_rd_trig_b,
    input wire logic i_cfg_clock,
    input wire logic i_cfg_load_done,
    input wire logic i_init_err,
    input wire cfg_pin_pkg::cfg_opt_t i_opt,
    input wire logic i_bscan_used,
    input wire logic i_tdo,
    input wire cfg_pin_pkg::host_port_t i_host_port,
    input wire logic [cfg_pin_pkg::NUM_PLL_PINS-1:0] i_pll_claim,
    input wire logic [cfg_pin_pkg::NUM_PCLK_PINS-1:0] i_pclk_used,
    input wire logic [cfg_pin_pkg::FRAME_W-1:0] i_rb_word,
    output logic [cfg_pin_pkg::MODE_W-1:0] o_mode,
    output logic o_tristate_all,
    output logic o_rd_data,
    output logic o_cfg_irq_b,
    output logic o_done,
    output logic o_done_oe_b,
    output logic o_mode_pins_user,
    output logic o_pll_hiz,
    output logic o_pll_pullup,
    output logic [cfg_pin_pkg::NUM_PLL_PINS-1:0] o_pll_user,
    output logic [cfg_pin_pkg::NUM_PCLK_PINS-1:0] o_pclk_user,
    output logic [cfg_pin_pkg::FADDR_W-1:0] o_rb_addr,
    output logic o_rb_busy
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic err_mode(input logic [cfg_pin_pkg::MODE_W-1:0] m);
        err_mode = (m == cfg_pin_pkg::MODE_JTAG) || (m == cfg_pin_pkg::MODE_SLAVE) ||
                   (m == cfg_pin_pkg::MODE_MASTER) || (m == cfg_pin_pkg::MODE_ASYNC_PERIPH);
    endfunction : err_mode

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    cfg_pin_pkg::cfg_state_t state_q, state_d;
    logic [cfg_pin_pkg::MODE_W-1:0] mode_q, mode_d;
    logic ts_q, ts_d;
    logic rd_q, rd_d;
    logic irq_b_q, irq_b_d;
    logic done_q, done_d;
    logic mpu_q, mpu_d;
    logic pll_hiz_q, pll_hiz_d;
    logic [cfg_pin_pkg::NUM_PLL_PINS-1:0] pll_user_q, pll_user_d;
    logic [cfg_pin_pkg::NUM_PCLK_PINS-1:0] pclk_user_q, pclk_user_d;

    logic [cfg_pin_pkg::EDGE_N-1:0] lvl;
    logic [cfg_pin_pkg::EDGE_N-1:0] rise;
    logic [cfg_pin_pkg::EDGE_N-1:0] fall;
    logic rb_start;
    logic rb_bit;
    logic in_user;

    assign lvl[cfg_pin_pkg::EDGE_INIT] = i_init_pin;
    assign lvl[cfg_pin_pkg::EDGE_TRIG] = i_rd_trig_b;
    assign lvl[cfg_pin_pkg::EDGE_CFG_CLOCK] = i_cfg_clock;
    assign in_user = (state_q == cfg_pin_pkg::ST_USER);

    pin_edge_detect u_edge (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_level(lvl),
        .o_rise(rise),
        .o_fall(fall)
    );

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    // readback only exists once the device is configured
    assign rb_start = in_user && i_opt.readback_en && fall[cfg_pin_pkg::EDGE_TRIG];

    // the host clocks readback data out on cfg clock rising edges
    readback_shifter u_rb (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_start(rb_start),
        .i_shift(rise[cfg_pin_pkg::EDGE_CFG_CLOCK]),
        .i_word(i_rb_word),
        .o_addr(o_rb_addr),
        .o_bit(rb_bit),
        .o_busy(o_rb_busy)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        case (state_q)
            cfg_pin_pkg::ST_WAIT: begin
                // held here as long as init stays low
                if (rise[cfg_pin_pkg::EDGE_INIT]) begin
                    mode_d = i_mode_sel;
                    state_d = cfg_pin_pkg::ST_CFG;
                end
            end
            cfg_pin_pkg::ST_CFG: begin
                if (i_cfg_load_done) begin
                    state_d = cfg_pin_pkg::ST_USER;
                end
            end
            cfg_pin_pkg::ST_USER: begin
                state_d = cfg_pin_pkg::ST_USER;
            end
            default: begin
                state_d = cfg_pin_pkg::ST_WAIT;
            end
        endcase

        // trigger only meaningful once init is high, which the host guarantees
        if (!in_user) begin
            ts_d = ~i_rd_trig_b;
        end else begin
            ts_d = i_opt.ts_after_cfg & ~i_rd_trig_b;
        end

        rd_d = i_bscan_used ? i_tdo : rb_bit;

        if (i_host_port.used) begin
            irq_b_d = ~i_host_port.irq;
        end else begin
            // error indication only in the listed modes and only before done
            irq_b_d = ~(!in_user && err_mode(mode_q) && i_init_err);
        end

        // done follows the next state so it rises with entry to user mode
        done_d = (state_d == cfg_pin_pkg::ST_USER);
        mpu_d = in_user;
        pll_hiz_d = ~in_user;
        pll_user_d = in_user ? ~i_pll_claim : '0;
        pclk_user_d = in_user ? ~i_pclk_used : '0;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_q <= cfg_pin_pkg::ST_WAIT;
            mode_q <= cfg_pin_pkg::MODE_RST;
            ts_q <= 1'b0;
            rd_q <= 1'b0;
            irq_b_q <= 1'b1;
            done_q <= 1'b0;
            mpu_q <= 1'b0;
            pll_hiz_q <= 1'b1;
            pll_user_q <= '0;
            pclk_user_q <= '0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            ts_q <= ts_d;
            rd_q <= rd_d;
            irq_b_q <= irq_b_d;
            done_q <= done_d;
            mpu_q <= mpu_d;
            pll_hiz_q <= pll_hiz_d;
            pll_user_q <= pll_user_d;
            pclk_user_q <= pclk_user_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_mode = mode_q;
    assign o_tristate_all = ts_q;
    assign o_rd_data = rd_q;
    assign o_cfg_irq_b = irq_b_q;
    // open drain: pulled low until done, then released so the pull-up reads high
    assign o_done = done_q;
    assign o_done_oe_b = done_q;
    assign o_mode_pins_user = mpu_q;
    assign o_pll_hiz = pll_hiz_q;
    // pull-ups share the tristate window; a split enable was not needed
    assign o_pll_pullup = pll_hiz_q;
    assign o_pll_user = pll_user_q;
    assign o_pclk_user = pclk_user_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_ts_cfg;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!in_user && !i_rd_trig_b) |=> o_tristate_all;
    endproperty
    a_ts_cfg: assert property (p_ts_cfg) else $error("tristate-all missing during config");

    property p_ts_user;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (in_user && !i_opt.ts_after_cfg) |=> !o_tristate_all;
    endproperty
    a_ts_user: assert property (p_ts_user) else $error("tristate-all active without option");

    property p_rb_start;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (in_user && i_opt.readback_en && $fell(i_rd_trig_b))
            |=> (o_rb_busy && o_rb_addr == cfg_pin_pkg::RB_FIRST_FRAME);
    endproperty
    a_rb_start: assert property (p_rb_start) else $error("readback not started at frame 0");

    property p_rd_tdo;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_bscan_used |=> (o_rd_data == $past(i_tdo));
    endproperty
    a_rd_tdo: assert property (p_rd_tdo) else $error("readback pin does not carry tdo");

    property p_irq_err;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!in_user && !i_host_port.used && err_mode(mode_q) && i_init_err) |=> !o_cfg_irq_b;
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("init error not signalled");

    property p_irq_host;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_host_port.used |=> (o_cfg_irq_b == !$past(i_host_port.irq));
    endproperty
    a_irq_host: assert property (p_irq_host) else $error("host irq not mirrored");

    property p_mode_latch;
        @(posedge i_mclk) disable iff (!i_rst_b)
        // edge detector restarts with init seen high, so no latch on the first edge
        ($past(i_rst_b) && state_q == cfg_pin_pkg::ST_WAIT && $rose(i_init_pin))
            |=> (o_mode == $past(i_mode_sel) && state_q == cfg_pin_pkg::ST_CFG) ##1
                (o_mode == $past(o_mode));
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not latched on init rise");

    property p_wait;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (state_q == cfg_pin_pkg::ST_WAIT && !i_init_pin) |=> state_q == cfg_pin_pkg::ST_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("left wait state with init low");

    property p_done;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (state_q == cfg_pin_pkg::ST_CFG && i_cfg_load_done) |=> (o_done && o_done_oe_b) ##1 o_done;
    endproperty
    a_done: assert property (p_done) else $error("done not released after config");

    property p_pll_cfg;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !in_user |=> (o_pll_hiz && o_pll_pullup && o_pll_user == '0 && !o_mode_pins_user);
    endproperty
    a_pll_cfg: assert property (p_pll_cfg) else $error("pins not held during config");

    property p_user_pins;
        @(posedge i_mclk) disable iff (!i_rst_b)
        in_user |=> (o_mode_pins_user && !o_pll_hiz && o_pll_user == ~$past(i_pll_claim)
                     && o_pclk_user == ~$past(i_pclk_used));
    endproperty
    a_user_pins: assert property (p_user_pins) else $error("pins not released to user");

    property p_rd_rb;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !i_bscan_used |=> (o_rd_data == $past(rb_bit));
    endproperty
    a_rd_rb: assert property (p_rd_rb) else $error("readback pin lost readback data");

    property p_irq_user;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (in_user && !i_host_port.used) |=> o_cfg_irq_b;
    endproperty
    a_irq_user: assert property (p_irq_user) else $error("error pin low after config");

    property p_ts_on;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (in_user && i_opt.ts_after_cfg && !i_rd_trig_b) |=> o_tristate_all;
    endproperty
    a_ts_on: assert property (p_ts_on) else $error("tristate-all missing with option");

    property p_rb_idle;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!o_rb_busy && !(in_user && i_opt.readback_en)) |=> !o_rb_busy;
    endproperty
    a_rb_idle: assert property (p_rb_idle) else $error("readback started without option");

endmodule : config_pin_control

/* File: cfg_host_model.sv */
// board-side configuration host: init, readback trigger, cfg clock, load done
// assumes the bench calls its tasks from the i_mclk domain

`timescale 1ns/1ps

module cfg_host_model (
    input wire logic i_mclk,
    output logic o_init_pin,
    output logic o_rd_trig_b,
    output logic o_cfg_clock,
    output logic o_cfg_load_done
);
    // ----------------------------------------------------------------
    // power-up levels
    // ----------------------------------------------------------------
    initial begin
        o_init_pin = 1'b0;
        o_rd_trig_b = 1'b1;
        o_cfg_clock = 1'b0;
        o_cfg_load_done = 1'b0;
    end

    // ----------------------------------------------------------------
    // pin actions, one change per clock edge
    // ----------------------------------------------------------------
    task automatic release_init();
        @(posedge i_mclk);
        o_init_pin <= 1'b1;
    endtask : release_init

    task automatic hold_init();
        @(posedge i_mclk);
        o_init_pin <= 1'b0;
    endtask : hold_init

    task automatic set_trig(input logic lvl);
        @(posedge i_mclk);
        // pull-up wins until init is released
        o_rd_trig_b <= o_init_pin ? lvl : 1'b1;
    endtask : set_trig

    task automatic load_done();
        @(posedge i_mclk);
        o_cfg_load_done <= 1'b1;
        @(posedge i_mclk);
        o_cfg_load_done <= 1'b0;
    endtask : load_done

    // high two cycles, low two; clock stands low between calls
    task automatic cfg_pulse();
        @(posedge i_mclk);
        o_cfg_clock <= 1'b1;
        repeat (2) @(posedge i_mclk);
        o_cfg_clock <= 1'b0;
        @(posedge i_mclk);
    endtask : cfg_pulse

endmodule : cfg_host_model

/* File: config_pin_control_tb.sv */
// self-checking bench for config_pin_control with a board host model
// assumes a 25 MHz clock and the frame geometry of cfg_pin_pkg

`timescale 1ns/1ps

module config_pin_control_tb;
    typedef struct packed {
        logic trig_b, err, used, irq, tdo, ts, irq_b, rd;
    } row_t;
    localparam row_t ROWS[5] = '{8'h82, 8'h4D, 8'hE2, 8'hB9, 8'h06};

    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] i_mode_sel = 4'h2;
    logic i_init_err = 1'b0, i_bscan_used = 1'b0, i_tdo = 1'b0;
    cfg_pin_pkg::cfg_opt_t i_opt = '0;
    cfg_pin_pkg::host_port_t i_host_port = '0;
    logic [7:0] i_pll_claim = 8'h0F, i_pclk_used = 8'h81;
    logic init_pin, rd_trig_b, cfg_clock, load;
    logic [15:0] rb_word;
    logic [3:0] o_mode;
    logic o_tristate_all, o_rd_data, o_cfg_irq_b, o_done, o_done_oe_b;
    logic o_mode_pins_user, o_pll_hiz, o_pll_pullup, o_rb_busy;
    logic [7:0] o_pll_user, o_pclk_user, o_rb_addr;
    int miscompares = 0, comparisons = 0, cycles = 0;

    always #20 i_mclk = ~i_mclk;
    // frame memory: contents derived from the frame address
    assign rb_word = {o_rb_addr, ~o_rb_addr};

    cfg_host_model host_u (.i_mclk(i_mclk), .o_init_pin(init_pin), .o_rd_trig_b(rd_trig_b),
        .o_cfg_clock(cfg_clock), .o_cfg_load_done(load));

    config_pin_control dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_init_pin(init_pin),
        .i_mode_sel(i_mode_sel), .i_rd_trig_b(rd_trig_b), .i_cfg_clock(cfg_clock),
        .i_cfg_load_done(load), .i_init_err(i_init_err), .i_opt(i_opt),
        .i_bscan_used(i_bscan_used), .i_tdo(i_tdo), .i_host_port(i_host_port),
        .i_pll_claim(i_pll_claim), .i_pclk_used(i_pclk_used), .i_rb_word(rb_word),
        .o_mode(o_mode), .o_tristate_all(o_tristate_all), .o_rd_data(o_rd_data),
        .o_cfg_irq_b(o_cfg_irq_b), .o_done(o_done), .o_done_oe_b(o_done_oe_b),
        .o_mode_pins_user(o_mode_pins_user), .o_pll_hiz(o_pll_hiz),
        .o_pll_pullup(o_pll_pullup), .o_pll_user(o_pll_user), .o_pclk_user(o_pclk_user),
        .o_rb_addr(o_rb_addr), .o_rb_busy(o_rb_busy));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : wait_n

    task automatic end_of_test();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // hang guard: whole run needs about 4240 cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 9000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        chk("reset flags", 16'({o_tristate_all, o_cfg_irq_b, o_done, o_done_oe_b,
            o_mode_pins_user, o_pll_hiz, o_pll_pullup, o_rb_busy}), 16'h0046);
        chk("reset user", {o_pll_user, o_pclk_user}, 16'h0000);
        host_u.load_done();
        wait_n(3);
        chk("done in wait", 16'(o_done), 16'h0000);
        host_u.release_init();
        @(posedge i_mclk);
        i_mode_sel <= 4'hA;
        wait_n(1);
        chk("mode latch", 16'(o_mode), 16'h0002);
        chk("pll in cfg", 16'({o_pll_hiz, o_pll_pullup, o_pll_user}), 16'h0300);
        chk("mode pins cfg", 16'(o_mode_pins_user), 16'h0000);
        i_bscan_used <= 1'b1;
        foreach (ROWS[k]) begin
            host_u.set_trig(ROWS[k].trig_b);
            i_init_err <= ROWS[k].err;
            i_host_port <= '{used: ROWS[k].used, irq: ROWS[k].irq};
            i_tdo <= ROWS[k].tdo;
            wait_n(2);
            chk("tristate", 16'(o_tristate_all), 16'(ROWS[k].ts));
            chk("irq pin", 16'(o_cfg_irq_b), 16'(ROWS[k].irq_b));
            chk("tdo", 16'(o_rd_data), 16'(ROWS[k].rd));
        end
        host_u.set_trig(1'b1);
        i_bscan_used <= 1'b0;
        i_host_port <= '0;
        host_u.load_done();
        wait_n(3);
        chk("done", 16'({o_done, o_done_oe_b}), 16'h0003);
        chk("mode pins user", 16'(o_mode_pins_user), 16'h0001);
        chk("pll user", 16'({o_pll_hiz, o_pll_user}), 16'h00F0);
        chk("pclk user", 16'(o_pclk_user), 16'h007E);
        chk("mode kept", 16'(o_mode), 16'h0002);
        // new claims after done still reach the user masks
        i_pll_claim <= 8'hC3;
        i_pclk_used <= 8'h3C;
        i_init_err <= 1'b1;
        wait_n(2);
        chk("irq after cfg", 16'(o_cfg_irq_b), 16'h0001);
        chk("pll user new", 16'(o_pll_user), 16'h003C);
        chk("pclk user new", 16'(o_pclk_user), 16'h00C3);
        i_host_port <= '{used: 1'b1, irq: 1'b1};
        wait_n(2);
        chk("host irq", 16'(o_cfg_irq_b), 16'h0000);
        i_host_port <= '0;
        i_init_err <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            i_opt <= '{ts_after_cfg: t[0], readback_en: 1'b0};
            host_u.set_trig(1'b0);
            wait_n(2);
            chk("ts after cfg", 16'(o_tristate_all), 16'(t));
            chk("no readback", 16'(o_rb_busy), 16'h0000);
            host_u.set_trig(1'b1);
        end
        i_opt <= '{ts_after_cfg: 1'b0, readback_en: 1'b1};
        host_u.set_trig(1'b0);
        wait_n(2);
        chk("rb start", 16'({o_rb_busy, o_rb_addr}), 16'h0100);
        host_u.set_trig(1'b1);
        repeat (20) host_u.cfg_pulse();
        #1;
        chk("rb addr step", 16'(o_rb_addr), 16'h0001);
        host_u.set_trig(1'b0);
        wait_n(2);
        chk("rb restart", 16'({o_rb_busy, o_rb_addr}), 16'h0100);
        host_u.set_trig(1'b1);
        for (int f = 0; f < 64; f++) begin
            chk("frame addr", 16'(o_rb_addr), 16'(f));
            for (int b = 15; b >= 0; b--) begin
                host_u.cfg_pulse();
                #1;
                chk("rb bit", 16'(o_rd_data), 16'({f[7:0], ~f[7:0]} >> b) & 16'h0001);
            end
        end
        wait_n(2);
        chk("rb stop", 16'(o_rb_busy), 16'h0000);
        // mid-run reset, then a mode code with no error report
        host_u.hold_init();
        i_rst_b <= 1'b0;
        i_init_err <= 1'b1;
        wait_n(2);
        @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        chk("reset again", 16'({o_tristate_all, o_cfg_irq_b, o_done, o_done_oe_b,
            o_mode_pins_user, o_pll_hiz, o_pll_pullup, o_rb_busy}), 16'h0046);
        chk("mode reset", 16'(o_mode), 16'h0000);
        host_u.release_init();
        wait_n(3);
        chk("mode relatch", 16'(o_mode), 16'h000A);
        chk("irq other mode", 16'(o_cfg_irq_b), 16'h0001);
        chk("done in cfg", 16'(o_done), 16'h0000);
        end_of_test();
    end

endmodule : config_pin_control_tb
